// ---- mic_irq_ctrl.sv ----
// interrupt controller top: apb registers, request flags, vectoring and wake-up
//
// Notes on behaviour
// - pin 1 selector: off, rise, fall, both
// - pin 0 selector in bits 1..0, same codes
// - source trigger sets its request flag
// - disabled flag stays set, no branch
// - global enable low blocks every interrupt
// - take: push next pc, load vector
// - return instruction pops the saved pc
// - every source owns a distinct vector
// - taking clears global enable, no nesting until software sets it again
// - requests while blocked still set flags
// - stack full blocks acknowledging any request
// - simultaneous requests resolved by fixed priority
// - newly set flag wakes from sleep/idle
// - unimplemented register bits read zero
// - flags and enables are software read/write
// - taking clears the serviced source flag
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "mic_defs.svh"
module mic_irq_ctrl #(
    parameter int PC_W = 13
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic ce, // clock enable, low freezes all state
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high writes
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error for unmapped address
    input wire logic [1:0] ext_pin, // external interrupt pins, asynchronous
    input wire logic [11:0] src_evt, // internal source trigger pulses
    input wire logic core_ready, // core at an instruction boundary
    input wire logic [PC_W-1:0] next_pc, // address of next instruction
    input wire logic stack_full, // core stack is full
    input wire logic return_from_interrupt_exec, // return instruction executes
    input wire logic low_power, // core sleeping or idle
    output logic stack_push, // push pulse
    output logic [PC_W-1:0] stack_push_pc, // pc to push
    output logic pc_load, // vector load pulse
    output logic [PC_W-1:0] pc_load_vec, // vector address
    output mic_pkg::mic_src_t taken_src, // source of last take
    output logic stack_pop, // pop pulse for return
    output logic wakeup // wake pulse
);
    import mic_pkg::*;

    localparam int NSRC = `MIC_NSRC;

    // ----------------------------------------
    // source table, index is priority rank
    // ----------------------------------------
    // 0 pin0, 1 pin1, 2 comparator0, 3 comparator1,
    // 4 converter, 5 timebase0, 6 timebase1, 7 serial,
    // 8 supply monitor, 9 eeprom, 10 std timer p,
    // 11 std timer a, 12 periodic timer p, 13 periodic timer a
    // one entry per source, in index order
    localparam mic_reg_e SRC_REG [NSRC] = '{
        MIC_REG_CTRL0, // pin0
        MIC_REG_CTRL0, // pin1
        MIC_REG_CTRL0, // comparator0
        MIC_REG_CTRL3, // comparator1
        MIC_REG_CTRL1, // converter
        MIC_REG_CTRL3, // timebase0
        MIC_REG_CTRL3, // timebase1
        MIC_REG_CTRL1, // serial
        MIC_REG_CTRL1, // supply monitor
        MIC_REG_CTRL1, // eeprom
        MIC_REG_CTRL2, // std timer p
        MIC_REG_CTRL2, // std timer a
        MIC_REG_CTRL2, // periodic timer p
        MIC_REG_CTRL2 // periodic timer a
    };
    localparam int SRC_EN_BIT [NSRC] = '{
        2, // pin0
        3, // pin1
        1, // comparator0
        2, // comparator1
        2, // converter
        0, // timebase0
        1, // timebase1
        0, // serial
        1, // supply monitor
        3, // eeprom
        2, // std timer p
        3, // std timer a
        0, // periodic timer p
        1 // periodic timer a
    };
    localparam int SRC_FL_BIT [NSRC] = '{
        5, // pin0
        6, // pin1
        4, // comparator0
        6, // comparator1
        6, // converter
        4, // timebase0
        5, // timebase1
        4, // serial
        5, // supply monitor
        7, // eeprom
        6, // std timer p
        7, // std timer a
        4, // periodic timer p
        5 // periodic timer a
    };

    // ----------------------------------------
    // address decode, shared by read and write
    // ----------------------------------------
    function automatic mic_reg_e decode(input logic [11:0] a);
        case (a)
            `MIC_OFS_EDGE: decode = MIC_REG_EDGE;
            `MIC_OFS_CTRL0: decode = MIC_REG_CTRL0;
            `MIC_OFS_CTRL1: decode = MIC_REG_CTRL1;
            `MIC_OFS_CTRL2: decode = MIC_REG_CTRL2;
            `MIC_OFS_CTRL3: decode = MIC_REG_CTRL3;
            default: decode = MIC_REG_NONE;
        endcase
    endfunction

    logic [3:0] edge_q;
    logic global_en_q;
    logic [NSRC-1:0] en_q;
    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] hw_set;
    logic [1:0] pin_evt;
    logic [31:0] rd_word;
    logic [7:0] rd_byte;
    logic [PC_W-1:0] push_pc_q, vec_q;
    mic_src_t src_q;
    logic push_q, load_q, pop_q, wake_q;
    mic_reg_e acc_reg;
    logic setup, access, bad, wr_en;
    logic take;

    mic_sel_if #(.NSRC(NSRC), .PC_W(PC_W)) sel_bus ();

    // ----------------------------------------
    // apb slave: zero wait states, read data captured in setup
    // ----------------------------------------
    assign acc_reg = decode(paddr);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign bad = (acc_reg == MIC_REG_NONE);
    // a frozen block holds the access open rather than drop a write
    assign pready = access && ce;
    assign pslverr = access && ce && bad;
    assign wr_en = access && ce && pwrite && !bad;

    always_comb begin
        rd_byte = `MIC_RST_BYTE;
        case (acc_reg)
            MIC_REG_EDGE: begin
                rd_byte[3:0] = edge_q;
            end
            MIC_REG_CTRL0, MIC_REG_CTRL1, MIC_REG_CTRL2, MIC_REG_CTRL3: begin
                if (acc_reg == MIC_REG_CTRL0) begin
                    rd_byte[`MIC_GLOBAL_BIT] = global_en_q;
                end
                for (int i = 0; i < NSRC; i++) begin
                    if (SRC_REG[i] == acc_reg) begin
                        rd_byte[SRC_EN_BIT[i]] = en_q[i];
                        rd_byte[SRC_FL_BIT[i]] = flag_q[i];
                    end
                end
            end
            default: begin
                rd_byte = `MIC_RST_BYTE;
            end
        endcase
        rd_word = {24'h000000, rd_byte};
    end

    // read data is taken at the setup edge so it is settled for the whole access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (ce && setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // ----------------------------------------
    // edge selectors for the two pins
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_q <= 4'h0;
        end else if (wr_en && acc_reg == MIC_REG_EDGE) begin
            edge_q <= pwdata[3:0];
        end
    end

    // pin 0 uses selector bits 1..0, pin 1 bits 3..2
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_pin
            mic_pin_edge u_edge (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .pin(ext_pin[g]),
                .mode(edge_q[2*g +: 2]),
                .evt(pin_evt[g])
            );
        end
    endgenerate

    // pins take the two highest ranks, peripheral pulses the rest
    assign hw_set = {src_evt, pin_evt};

    // ----------------------------------------
    // request selection and take decision
    // ----------------------------------------
    // a disabled flag still reads set but never requests
    assign sel_bus.req = flag_q & en_q;

    // one winner per cycle; the others stay pending for later takes
    mic_prio_sel u_sel (
        .s(sel_bus.sel)
    );

    // take only at a boundary, with global enable and room on the stack
    // the core sees push and load one cycle after this edge
    assign take = ce && core_ready && global_en_q && !stack_full && sel_bus.hit;

    // ----------------------------------------
    // per-source flags and enables
    // ----------------------------------------
    generate
        for (g = 0; g < NSRC; g++) begin : gen_src
            logic wr_here;
            assign wr_here = wr_en && (acc_reg == SRC_REG[g]);

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q[g] <= 1'b0;
                end else if (ce) begin
                    if (hw_set[g]) begin
                        // a new event beats any clear in the same cycle
                        flag_q[g] <= 1'b1;
                    end else if (take && sel_bus.idx == mic_src_t'(g)) begin
                        flag_q[g] <= 1'b0;
                    end else if (wr_here) begin
                        flag_q[g] <= pwdata[SRC_FL_BIT[g]];
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    en_q[g] <= 1'b0;
                end else if (wr_here) begin
                    en_q[g] <= pwdata[SRC_EN_BIT[g]];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // global enable
    // ----------------------------------------
    // hardware clear on take wins over a write in the same cycle;
    // software re-enables inside the handler to allow nesting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            global_en_q <= 1'b0;
        end else if (ce) begin
            if (take) begin
                global_en_q <= 1'b0;
            end else if (wr_en && acc_reg == MIC_REG_CTRL0) begin
                global_en_q <= pwdata[`MIC_GLOBAL_BIT];
            end
        end
    end

    // ----------------------------------------
    // core side: push, vector load, return pop
    // ----------------------------------------
    // pulses last one cycle; the data below stands until the next take
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_q <= 1'b0;
            load_q <= 1'b0;
        end else if (ce) begin
            push_q <= take;
            load_q <= take;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_pc_q <= '0;
            vec_q <= '0;
            src_q <= '0;
        end else if (ce) begin
            if (take) begin
                push_pc_q <= next_pc;
                vec_q <= sel_bus.vec;
                src_q <= sel_bus.idx;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pop_q <= 1'b0;
        end else if (ce) begin
            pop_q <= return_from_interrupt_exec;
        end
    end

    // ----------------------------------------
    // wake-up from sleep or idle
    // ----------------------------------------
    // only a flag going from clear to set wakes, so a flag set
    // beforehand by software suppresses the wake-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
        end else if (ce) begin
            wake_q <= low_power && |(hw_set & ~flag_q);
        end
    end

    // ----------------------------------------
    // outputs, all straight from registers
    // ----------------------------------------
    assign stack_push = push_q;
    assign stack_push_pc = push_pc_q;
    assign pc_load = load_q;
    assign pc_load_vec = vec_q;
    assign taken_src = src_q;
    assign stack_pop = pop_q;
    assign wakeup = wake_q;
endmodule

// ---- mic_defs.svh ----
// register map, field positions, reset values and vector constants of the interrupt controller
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MIC_OFS_EDGE 12'h000
`define MIC_OFS_CTRL0 12'h004
`define MIC_OFS_CTRL1 12'h008
`define MIC_OFS_CTRL2 12'h00c
`define MIC_OFS_CTRL3 12'h010

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MIC_RST_BYTE 8'h00
`define MIC_GLOBAL_BIT 0
`define MIC_PIN0_SEL_LSB 0
`define MIC_PIN1_SEL_LSB 2
`define MIC_NSRC 14

// ----------------------------------------
// vector table: base plus source index times step
// ----------------------------------------
`define MIC_VEC_BASE 16'h0004
`define MIC_VEC_STEP 16'h0004

`endif

// ---- mic_pkg.sv ----
// shared types of the interrupt controller
package mic_pkg;

    // ----------------------------------------
    // register selector
    // ----------------------------------------
    typedef enum logic [2:0] {
        MIC_REG_EDGE = 3'h0,
        MIC_REG_CTRL0 = 3'h1,
        MIC_REG_CTRL1 = 3'h2,
        MIC_REG_CTRL2 = 3'h3,
        MIC_REG_CTRL3 = 3'h4,
        MIC_REG_NONE = 3'h7
    } mic_reg_e;

    // ----------------------------------------
    // edge selector codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        MIC_EDGE_OFF = 2'h0,
        MIC_EDGE_RISE = 2'h1,
        MIC_EDGE_FALL = 2'h2,
        MIC_EDGE_BOTH = 2'h3
    } mic_edge_e;

    // source index, also the priority rank (0 highest)
    typedef logic [3:0] mic_src_t;

endpackage

// ---- mic_sel_if.sv ----
// carrier between the flag logic and the priority selector
`timescale 1ns/100ps
interface mic_sel_if #(parameter int NSRC = 14, parameter int PC_W = 13);
    logic [NSRC-1:0] req;
    logic hit;
    mic_pkg::mic_src_t idx;
    logic [PC_W-1:0] vec;
    modport ctrl (output req, input hit, input idx, input vec);
    modport sel (input req, output hit, output idx, output vec);
endinterface

// ---- mic_pin_edge.sv ----
// synchroniser and selectable edge detector for one external interrupt pin
`timescale 1ns/100ps
module mic_pin_edge (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic pin, // raw pin level
    input wire logic [1:0] mode, // edge selector code
    output logic evt // one-cycle edge event
);
    import mic_pkg::*;

    logic s1_q, s2_q, s3_q, level_q, primed_q;
    logic stable, changed;

    // ----------------------------------------
    // three-stage synchroniser
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign stable = (s2_q == s3_q);
    assign changed = stable && primed_q && (s3_q != level_q);

    // first agreed sample only loads the level; the synchroniser resets low, so a pin high at reset shows as a rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
            primed_q <= 1'b0;
        end else if (ce && stable) begin
            level_q <= s3_q;
            primed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt <= 1'b0;
        end else if (ce) begin
            evt <= changed && ((s3_q && mode[0]) || (!s3_q && mode[1]));
        end
    end
endmodule

// ---- mic_prio_sel.sv ----
// fixed-priority selector: lowest requesting index wins and gets its own vector
`timescale 1ns/100ps
`include "mic_defs.svh"
module mic_prio_sel (
    mic_sel_if.sel s // request set in, winner out
);
    import mic_pkg::*;

    localparam int NSRC = $bits(s.req);
    localparam int PC_W = $bits(s.vec);

    logic [15:0] vec_w;

    always_comb begin
        s.hit = 1'b0;
        s.idx = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (s.req[i]) begin
                s.hit = 1'b1;
                s.idx = mic_src_t'(i);
            end
        end
    end

    // distinct vector per source
    assign vec_w = 16'(`MIC_VEC_BASE + 16'(s.idx) * `MIC_VEC_STEP);
    assign s.vec = vec_w[PC_W-1:0];
endmodule

// ---- mic_core_model.sv ----
// behavioural model of the core stack and program counter facing the controller
`timescale 1ns/100ps
module mic_core_model #(
    parameter int PC_W = 13,
    parameter int DEPTH = 2
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic stack_push, // push pulse
    input wire logic [PC_W-1:0] stack_push_pc, // pc to push
    input wire logic pc_load, // vector load pulse
    input wire logic [PC_W-1:0] pc_load_vec, // vector address
    input wire logic stack_pop, // pop pulse
    input wire logic return_from_interrupt_req, // bench asks for a return
    input wire logic slow, // core_ready only every other cycle
    output logic core_ready, // instruction boundary
    output logic [PC_W-1:0] next_pc, // next instruction address
    output logic stack_full, // stack full
    output logic return_from_interrupt_exec // return executes
);
    logic [PC_W-1:0] stk_q [DEPTH];
    int depth_q;
    assign stack_full = (depth_q == DEPTH);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_ready <= 1'b0;
            next_pc <= '0;
            return_from_interrupt_exec <= 1'b0;
            depth_q <= 0;
        end else begin
            core_ready <= slow ? ~core_ready : 1'b1;
            return_from_interrupt_exec <= return_from_interrupt_req && depth_q > 0;
            if (pc_load) begin
                next_pc <= pc_load_vec;
            end else if (stack_pop) begin
                next_pc <= stk_q[depth_q-1];
            end else if (core_ready) begin
                next_pc <= next_pc + 1'b1;
            end
            if (stack_push) begin
                stk_q[depth_q] <= stack_push_pc;
                depth_q <= depth_q + 1;
            end else if (stack_pop) begin
                depth_q <= depth_q - 1;
            end
        end
    end
endmodule

// ---- mic_irq_ctrl_sva.sv ----
// port assertions of the interrupt controller
`timescale 1ns/100ps
module mic_irq_ctrl_sva #(
    parameter int PC_W = 13
) (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic ce, // clock enable
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic core_ready, // boundary
    input wire logic [PC_W-1:0] next_pc, // next pc
    input wire logic stack_full, // stack full
    input wire logic return_from_interrupt_exec, // return
    input wire logic low_power, // sleep or idle
    input wire logic stack_push, // push
    input wire logic [PC_W-1:0] stack_push_pc, // pushed pc
    input wire logic pc_load, // load
    input wire logic [PC_W-1:0] pc_load_vec, // vector
    input wire mic_pkg::mic_src_t taken_src, // source
    input wire logic stack_pop, // pop
    input wire logic wakeup // wake
);
    import mic_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_push_pair; stack_push |-> pc_load && stack_push_pc == $past(next_pc); endproperty
    a_push_pair: assert property (p_push_pair) else $error("push without matching load");
    property p_vec; pc_load |-> pc_load_vec == PC_W'(16'h0004 + {taken_src, 2'b00}); endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_full; stack_full |=> !stack_push; endproperty
    a_full: assert property (p_full) else $error("take while stack full");
    property p_ready; !core_ready |=> !stack_push; endproperty
    a_ready: assert property (p_ready) else $error("take off a boundary");
    property p_nest; stack_push |=> !stack_push; endproperty
    a_nest: assert property (p_nest) else $error("nested take");
    property p_pop; return_from_interrupt_exec && ce |=> stack_pop ##1 !stack_pop || $past(return_from_interrupt_exec); endproperty
    a_pop: assert property (p_pop) else $error("no pop after return");
    property p_wake; !low_power |=> !wakeup; endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_zero; psel && penable && ce |-> pready; endproperty
    a_zero: assert property (p_zero) else $error("access not answered");
    property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_edge_hi; pready && !pwrite && paddr == 12'h000 |-> prdata[7:4] == 4'h0; endproperty
    a_edge_hi: assert property (p_edge_hi) else $error("edge register high bits set");
endmodule
bind mic_irq_ctrl mic_irq_ctrl_sva #(.PC_W(PC_W)) u_sva (.*);

// ---- mic_irq_ctrl_tb.sv ----
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
module mic_irq_ctrl_tb;
    import mic_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, src_evt = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, core_ready, stack_full, return_from_interrupt_exec, stack_push, pc_load, stack_pop, wakeup, err;
    logic [1:0] ext_pin = 2'h0;
    logic low_power = 1'b0, return_from_interrupt_req = 1'b0, slow = 1'b0;
    logic [12:0] next_pc, stack_push_pc, pc_load_vec;
    mic_src_t taken_src;
    logic [7:0] wv [5] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hff};
    logic [7:0] ev [5] = '{8'h0f, 8'h7e, 8'hff, 8'hff, 8'h77};
    int fails = 0, tests_run = 0, cyc = 0, pushes = 0, wakes = 0;
    always #4 clk = ~clk;
    mic_irq_ctrl #(.PC_W(13)) DUT (.*);
    mic_core_model #(.PC_W(13), .DEPTH(2)) u_core (.clk(clk), .rst_n(rst_n), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .pc_load(pc_load), .pc_load_vec(pc_load_vec), .stack_pop(stack_pop),
        .return_from_interrupt_req(return_from_interrupt_req), .slow(slow), .core_ready(core_ready), .next_pc(next_pc),
        .stack_full(stack_full), .return_from_interrupt_exec(return_from_interrupt_exec));
    // ----------------------------------------
    // monitors and helpers
    // ----------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pushes <= pushes + stack_push;
        wakes <= wakes + wakeup;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task summarize;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task pulse_return_from_interrupt;
        @(posedge clk);
        return_from_interrupt_req <= 1'b1;
        @(posedge clk);
        return_from_interrupt_req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task evt(input int k);
        @(posedge clk);
        src_evt[k] <= 1'b1;
        @(posedge clk);
        src_evt <= 12'h000;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) rdchk(12'(a * 4), 8'h00);
        apb(1'b0, 12'h014, 8'h00);
        chk(err, 1);
        for (int a = 0; a < 5; a++) begin
            apb(1'b1, 12'(a * 4), wv[a]);
            rdchk(12'(a * 4), ev[a]);
            apb(1'b1, 12'(a * 4), 8'h00);
        end
        for (int k = 0; k < 12; k++) evt(k);
        rdchk(12'h004, 8'h10);
        rdchk(12'h008, 8'hf0);
        rdchk(12'h00c, 8'hf0);
        rdchk(12'h010, 8'h70);
        apb(1'b1, 12'h004, 8'h11);
        repeat (4) @(posedge clk);
        chk(pushes, 0);
        apb(1'b1, 12'h004, 8'h12);
        apb(1'b1, 12'h008, 8'hff);
        apb(1'b1, 12'h00c, 8'hff);
        apb(1'b1, 12'h010, 8'h77);
        chk(pushes, 0);
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            apb(1'b1, 12'h004, (i == 0) ? 8'h13 : 8'h03);
            for (int n = 0; n < 20 && pushes <= i; n++) @(posedge clk);
            chk(taken_src, i + 2);
            chk(pc_load_vec, 4 + 4 * (i + 2));
            rdchk(12'h004, 8'h02);
            pulse_return_from_interrupt();
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h010, 8'h11);
            apb(1'b1, 12'h004, 8'h01);
            repeat (3) @(posedge clk);
        end
        chk(pushes, 14);
        pulse_return_from_interrupt();
        repeat (6) @(posedge clk);
        chk(pushes, 15);
        apb(1'b1, 12'h004, 8'h00);
        apb(1'b1, 12'h010, 8'h00);
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                apb(1'b1, 12'h000, 8'(m << (2 * p)));
                ext_pin[p] <= 1'b1;
                repeat (8) @(posedge clk);
                rdchk(12'h004, 8'((m % 2) << (5 + p)));
                apb(1'b1, 12'h004, 8'h00);
                ext_pin[p] <= 1'b0;
                repeat (8) @(posedge clk);
                rdchk(12'h004, 8'((m / 2) << (5 + p)));
                apb(1'b1, 12'h004, 8'h00);
            end
        end
        apb(1'b1, 12'h000, 8'h00);
        ext_pin <= 2'h3;
        repeat (8) @(posedge clk);
        rdchk(12'h004, 8'h00);
        ext_pin <= 2'h0;
        ce <= 1'b0;
        evt(1);
        ce <= 1'b1;
        rdchk(12'h010, 8'h00);
        low_power <= 1'b1;
        evt(0);
        evt(0);
        repeat (3) @(posedge clk);
        chk(wakes, 1);
        summarize();
    end
endmodule
